// ---- pkg/rdm_params.svh ----
// Purpose: Constants for the radio diagnostic signal multiplexer
// Assumes: Select words come straight from core configuration flops
// Notes:   Scheme codes and port order word as programmed by software
`ifndef RDM_PARAMS_SVH
`define RDM_PARAMS_SVH
`define RDM_NUM_PORTS      8
`define RDM_SEL_EVENTS     32'h8383_8383
`define RDM_SEL_BITSTREAM  32'h9292_9292
`define RDM_ORDER_NATURAL  32'h7654_3210
`define RDM_PORTS_LOW      8'h00
`endif

// ---- pkg/rdm_pkg.sv ----
// Purpose: Types for the radio diagnostic signal multiplexer
// Assumes: Constants live in rdm_params.svh
// Notes:   Scheme encoding is internal only
package rdm_pkg;
	// Active routing scheme
	typedef enum logic [1:0] {
		RDM_SCHEME_OFF    = 2'b00,
		RDM_SCHEME_EVENTS = 2'b01,
		RDM_SCHEME_BITS   = 2'b10
	} rdm_scheme_t;
	// Diagnostic port bundle
	typedef logic [7:0] rdm_ports_t;
endpackage

// ---- core/rdm_mux.sv ----
// Purpose: Route internal link-layer signals to eight diagnostic pins
// Assumes: All inputs synchronous to mclk_i; source logic shapes pulses
// Notes:   Outputs registered, one cycle behind their sources
`timescale 1ns/1ps
`include "rdm_params.svh"

module rdm_mux (
	input  wire logic              mclk_i,
	input  wire logic              rst_b_i,
	input  wire logic [31:0]       diag_select_a_i,
	input  wire logic [31:0]       diag_select_b_i,
	input  wire logic [31:0]       diag_port_order_i,
	input  wire logic              radio_tx_enable_i,
	input  wire logic              radio_rx_enable_i,
	input  wire logic              access_addr_corr_window_i,
	input  wire logic              access_addr_hit_pulse_i,
	input  wire logic              link_event_active_i,
	input  wire logic              event_end_pulse_i,
	input  wire logic              packet_rx_pulse_i,
	input  wire logic              mem_conflict_pulse_i,
	input  wire logic              pkt_ctrl_rx_bit_i,
	input  wire logic              pkt_ctrl_rx_valid_i,
	input  wire logic              stream_engine_rx_bit_i,
	input  wire logic              stream_engine_rx_valid_i,
	input  wire logic              pkt_ctrl_tx_bit_i,
	input  wire logic              pkt_ctrl_tx_valid_i,
	input  wire logic              stream_engine_tx_bit_i,
	input  wire logic              stream_engine_tx_valid_i,
	output rdm_pkg::rdm_ports_t    diag_port_o
);
	import rdm_pkg::*;

	// Decoded scheme
	wire logic        order_ok;
	wire logic        sel_events;
	wire logic        sel_bits;
	rdm_scheme_t      scheme;
	// Candidate port groups
	wire logic [7:0]  events_group;
	wire logic [7:0]  bits_group;
	wire logic [7:0]  diag_next;
	logic [7:0]       diag_next_c; // Combinational select result
	// Output flops and the word they clear to
	logic [7:0]       diag_reg;
	localparam rdm_ports_t PORTS_LOW = `RDM_PORTS_LOW;

	// Scheme decode from the three select words
	// All three words must match; a half written set stays off
	// The order word is only honoured at its natural value
	assign order_ok   = (diag_port_order_i == `RDM_ORDER_NATURAL);
	assign sel_events = order_ok
		&& (diag_select_a_i == `RDM_SEL_EVENTS)
		&& (diag_select_b_i == `RDM_SEL_EVENTS);
	assign sel_bits   = order_ok
		&& (diag_select_a_i == `RDM_SEL_BITSTREAM)
		&& (diag_select_b_i == `RDM_SEL_BITSTREAM);
	assign scheme = sel_events ? RDM_SCHEME_EVENTS
		: (sel_bits ? RDM_SCHEME_BITS : RDM_SCHEME_OFF);

	// Event scheme: bit n goes to port n
	// Window and hit pulse are passed unaltered from correlator
	assign events_group = {
		mem_conflict_pulse_i,
		packet_rx_pulse_i,
		event_end_pulse_i,
		link_event_active_i,
		access_addr_hit_pulse_i,
		access_addr_corr_window_i,
		radio_rx_enable_i,
		radio_tx_enable_i};

	// Bit scheme: each data bit beside its qualifier
	// Stream engine bits come from the CRC and whitening stage
	assign bits_group = {
		stream_engine_tx_valid_i,
		stream_engine_tx_bit_i,
		pkt_ctrl_tx_valid_i,
		pkt_ctrl_tx_bit_i,
		stream_engine_rx_valid_i,
		stream_engine_rx_bit_i,
		pkt_ctrl_rx_valid_i,
		pkt_ctrl_rx_bit_i};

	// Port selection, low when no scheme matches
	always_comb begin
		case (scheme)
			RDM_SCHEME_EVENTS: diag_next_c = events_group;
			RDM_SCHEME_BITS:   diag_next_c = bits_group;
			default:           diag_next_c = `RDM_PORTS_LOW;
		endcase
	end
	// Selected word handed to the port flops
	assign diag_next = diag_next_c;

	// Output register, one flop per fixed port
	// Registering hides select decode glitches from the pins
	generate
		for (genvar p = 0; p < `RDM_NUM_PORTS; p++) begin : g_port
			// Port flop, low while reset is held
			always_ff @(posedge mclk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					diag_reg[p] <= PORTS_LOW[p];
				end else begin
					diag_reg[p] <= diag_next[p];
				end
			end
		end
	endgenerate
	// Pins see the flops directly, no logic after them
	assign diag_port_o = diag_reg;

	// Routing checks: each port shows its source one edge later
	// All but the reset check are muted while reset is held low

	// Whole event word follows its sources
	property p_events;
		@(posedge mclk_i) disable iff (!rst_b_i)
		sel_events |=> diag_port_o == $past(events_group);
	endproperty
	AST_EVENTS_MAP: assert property (p_events)
		else $error("event scheme routing wrong");

	// Event active level carried to port 4
	AST_EVENTS_HIGH: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && link_event_active_i |=> diag_port_o[4])
		else $error("event active not on port 4");

	// Memory conflict pulse carried to port 7
	AST_CONFLICT: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && mem_conflict_pulse_i |=> diag_port_o[7])
		else $error("conflict pulse not on port 7");

	// No hit on port 3 unless the correlator reported one
	AST_HIT_ONLY: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && !access_addr_hit_pulse_i |=> !diag_port_o[3])
		else $error("hit pulse without source");

	// Whole bit stream word follows its sources
	AST_BITS_MAP: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits |=> diag_port_o == $past(bits_group))
		else $error("bit scheme routing wrong");

	// Stream engine transmit bit on port 6
	AST_BITS_TX: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits && stream_engine_tx_bit_i |=> diag_port_o[6])
		else $error("stream tx bit not on port 6");

	// No matching scheme keeps every port low
	AST_OFF_LOW: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		!sel_events && !sel_bits |=> diag_port_o == PORTS_LOW)
		else $error("ports not low when unselected");

	// A wrong order word blocks both schemes
	AST_ORDER: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		!order_ok |=> diag_port_o == PORTS_LOW)
		else $error("bad port order not blocked");

	// Correlation window level on port 2
	AST_WINDOW: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events [*2] |-> diag_port_o[2]
		== $past(access_addr_corr_window_i))
		else $error("window not on port 2");

	// Event end pulse on port 5
	AST_END: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && event_end_pulse_i |=> diag_port_o[5])
		else $error("end pulse not on port 5");

	// Packet received pulse on port 6
	AST_RX: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && packet_rx_pulse_i |=> diag_port_o[6])
		else $error("rx pulse not on port 6");

	// Stream engine receive bit on port 2
	AST_STREAM_RX: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits && stream_engine_rx_bit_i |=> diag_port_o[2])
		else $error("stream rx bit not on port 2");

	// Reset seen at an edge leaves all ports low at the next
	AST_RESET_LOW: assert property (@(posedge mclk_i)
		!rst_b_i |=> diag_port_o == PORTS_LOW)
		else $error("ports not low in reset");

	// Radio transmit enable on port 0
	AST_TX_EN: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && radio_tx_enable_i |=> diag_port_o[0])
		else $error("tx enable not on port 0");

	// Radio receive enable on port 1
	AST_RX_EN: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && radio_rx_enable_i |=> diag_port_o[1])
		else $error("rx enable not on port 1");

	// Upper half of the event word in its fixed order
	AST_UPPER: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events |=> diag_port_o[7:4] == $past(events_group[7:4]))
		else $error("event ports 4 to 7 wrong");

	// Window low on port 2 while not searching
	AST_WIN_LOW: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && !access_addr_corr_window_i |=> !diag_port_o[2])
		else $error("window high without search");

	// Correlator hit reaches port 3
	AST_HIT: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && access_addr_hit_pulse_i |=> diag_port_o[3])
		else $error("hit pulse not on port 3");

	// Port 4 low when no event is running
	AST_EVENT_LOW: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && !link_event_active_i |=> !diag_port_o[4])
		else $error("event active without source");

	// Port 4 stays up across a running event
	AST_EVENT_SPAN: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		(sel_events && link_event_active_i) [*2] |-> diag_port_o[4])
		else $error("event active dropped mid event");

	// No end pulse on port 5 without its source
	AST_END_LOW: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && !event_end_pulse_i |=> !diag_port_o[5])
		else $error("end pulse without source");

	// No packet pulse on port 6 without its source
	AST_RX_LOW: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && !packet_rx_pulse_i |=> !diag_port_o[6])
		else $error("rx pulse without source");

	// No conflict pulse on port 7 without its source
	AST_CONFLICT_LOW: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_events && !mem_conflict_pulse_i |=> !diag_port_o[7])
		else $error("conflict pulse without source");

	// Packet controller receive bit on port 0
	AST_PKT_RX: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits && pkt_ctrl_rx_bit_i |=> diag_port_o[0])
		else $error("packet rx bit not on port 0");

	// Packet controller receive qualifier on port 1
	AST_PKT_RXV: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits && pkt_ctrl_rx_valid_i |=> diag_port_o[1])
		else $error("packet rx valid not on port 1");

	// Stream engine receive qualifier on port 3
	AST_STREAM_RXV: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits && stream_engine_rx_valid_i |=> diag_port_o[3])
		else $error("stream rx valid not on port 3");

	// Packet controller transmit bit on port 4
	AST_PKT_TX: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits && pkt_ctrl_tx_bit_i |=> diag_port_o[4])
		else $error("packet tx bit not on port 4");

	// Packet controller transmit qualifier on port 5
	AST_PKT_TXV: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits && pkt_ctrl_tx_valid_i |=> diag_port_o[5])
		else $error("packet tx valid not on port 5");

	// Stream engine transmit qualifier on port 7
	AST_STREAM_TXV: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits && stream_engine_tx_valid_i |=> diag_port_o[7])
		else $error("stream tx valid not on port 7");

	// Port 2 low when the stream receive bit is low
	AST_STREAM_RX_LOW: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits && !stream_engine_rx_bit_i |=> !diag_port_o[2])
		else $error("stream rx bit high without source");

	// Port 6 low when the stream transmit bit is low
	AST_STREAM_TX_LOW: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		sel_bits && !stream_engine_tx_bit_i |=> !diag_port_o[6])
		else $error("stream tx bit high without source");

	// Main scenarios
	// Event scheme selected
	COV_EVENTS: cover property (@(posedge mclk_i) sel_events);
	// Bit stream scheme selected
	COV_BITS: cover property (@(posedge mclk_i) sel_bits);
	// Access address hit routed out
	COV_HIT: cover property (@(posedge mclk_i)
		sel_events && access_addr_hit_pulse_i);
	// Scheme switched on the fly
	COV_SWITCH: cover property (@(posedge mclk_i)
		sel_events ##1 sel_bits);
	// Bad order word refused
	COV_REFUSED: cover property (@(posedge mclk_i)
		rst_b_i && !order_ok);
endmodule

// ---- verification/rdm_probe.sv ----
// Purpose: Probe model standing on the eight diagnostic pins
// Assumes: Pins are sampled on the core clock
// Notes:   Shows the pin pattern of the previous edge
`timescale 1ns/1ps

module rdm_probe (
	input  wire logic       mclk_i,
	input  wire logic [7:0] pin_i,
	output logic      [7:0] seen_o
);
	// Capture all pins on each edge
	always_ff @(posedge mclk_i) begin
		seen_o <= pin_i;
	end
endmodule

// ---- verification/rdm_mux_bench.sv ----
// Purpose: Self-checking bench for the diagnostic multiplexer
// Assumes: One cycle latency through the block, probe adds one
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`include "rdm_params.svh"

module rdm_mux_bench;
	import rdm_pkg::*;
	logic        mclk = 0;
	logic        rst_b = 0;
	logic [31:0] sa = 0, sb = 0, so = 0; // Select words
	logic [7:0]  s1 = 0, s2 = 0;         // Scheme one and two sources
	rdm_ports_t  port;
	logic [7:0]  seen;
	int          n_errors = 0, comparisons = 0;
	always #50 mclk = ~mclk;
	rdm_mux uut (.mclk_i(mclk), .rst_b_i(rst_b), .diag_select_a_i(sa),
		.diag_select_b_i(sb), .diag_port_order_i(so),
		.radio_tx_enable_i(s1[0]), .radio_rx_enable_i(s1[1]),
		.access_addr_corr_window_i(s1[2]), .access_addr_hit_pulse_i(s1[3]),
		.link_event_active_i(s1[4]), .event_end_pulse_i(s1[5]),
		.packet_rx_pulse_i(s1[6]), .mem_conflict_pulse_i(s1[7]),
		.pkt_ctrl_rx_bit_i(s2[0]), .pkt_ctrl_rx_valid_i(s2[1]),
		.stream_engine_rx_bit_i(s2[2]), .stream_engine_rx_valid_i(s2[3]),
		.pkt_ctrl_tx_bit_i(s2[4]), .pkt_ctrl_tx_valid_i(s2[5]),
		.stream_engine_tx_bit_i(s2[6]), .stream_engine_tx_valid_i(s2[7]),
		.diag_port_o(port));
	rdm_probe prb (.mclk_i(mclk), .pin_i(port), .seen_o(seen));
	// Compare and count
	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Drive one sample, return what the probe saw of it
	task automatic apply(logic [31:0] a, b, o, logic [7:0] v1, v2,
		output logic [7:0] got);
		{sa, sb, so, s1, s2} = {a, b, o, v1, v2};
		repeat (2) @(posedge mclk);
		#1 got = seen;
	endtask
	// Walk one source at a time, other scheme noisy
	task automatic schemes();
		logic [7:0] g;
		for (int i = 0; i < 8; i++) begin
			apply(`RDM_SEL_EVENTS, `RDM_SEL_EVENTS, `RDM_ORDER_NATURAL,
				8'h01 << i, ~(8'h01 << i), g);
			check("scheme one", 8'h01 << i, g);
			apply(`RDM_SEL_BITSTREAM, `RDM_SEL_BITSTREAM, `RDM_ORDER_NATURAL,
				~(8'h01 << i), 8'h01 << i, g);
			check("scheme two", 8'h01 << i, g);
		end
	endtask
	// Non-matching words give all ports low
	task automatic refused();
		logic [7:0]  g;
		logic [31:0] t[4] = '{`RDM_SEL_EVENTS, `RDM_SEL_BITSTREAM,
			32'h8383_8382, 32'h7654_3201};
		apply(t[0], t[1], `RDM_ORDER_NATURAL, 8'hff, 8'hff, g);
		check("mixed select", 8'h00, g);
		apply(t[2], t[0], `RDM_ORDER_NATURAL, 8'hff, 8'hff, g);
		check("bad select a", 8'h00, g);
		apply(t[1], t[1], t[3], 8'hff, 8'hff, g);
		check("bad order", 8'h00, g);
	endtask
	// Ports are flops: a change shows after one edge, not before
	task automatic latency();
		logic [7:0] g;
		apply(`RDM_SEL_EVENTS, `RDM_SEL_EVENTS, `RDM_ORDER_NATURAL,
			8'h3c, 8'h00, g);
		check("steady", 8'h3c, g);
		s1 = 8'hc3;
		#1 check("before edge", 8'h3c, port);
		@(posedge mclk);
		#1 check("one cycle", 8'hc3, port);
	endtask
	// Mid-run reset clears lit ports at once and holds them low
	task automatic reset_mid();
		logic [7:0] g;
		apply(`RDM_SEL_EVENTS, `RDM_SEL_EVENTS, `RDM_ORDER_NATURAL,
			8'hff, 8'h00, g);
		check("before reset", 8'hff, g);
		rst_b = 0;
		#1 check("reset", 8'h00, port);
		@(posedge mclk);
		#1 check("reset held", 8'h00, port);
		rst_b = 1;
	endtask
	task automatic give_verdict();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge mclk);
		#1 rst_b = 1;
		schemes();
		refused();
		latency();
		reset_mid();
		schemes();
		give_verdict();
	end
endmodule
